// ---- src/window_watchdog_pkg.sv ----
// Purpose: constants shared by the window watchdog design files
// Assumes: 32-bit APB register bus, one word per register
// Notes: offsets are byte addresses
package window_watchdog_pkg;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] CFG_OFFSET = 12'h004;
  localparam logic [11:0] STAT_OFFSET = 12'h008;
  localparam logic [11:0] SWRST_OFFSET = 12'h00c;
  localparam int COUNT_MSB = 6;
  localparam int RUN_BIT = 7;
  localparam int DIV_LSB = 7;
  localparam int DIV_MSB = 8;
  localparam int EARLY_WARNING_IRQ_ENABLE_BIT = 9;
  localparam int EARLY_WARNING_FLAG_BIT = 0;
  localparam logic [6:0] COUNT_RESET = 7'h7f;
  localparam logic [6:0] WINDOW_RESET = 7'h7f;
  localparam logic [6:0] WARN_VALUE = 7'h40;
  localparam logic [6:0] EXPIRE_VALUE = 7'h3f;
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam int BASE_DIVIDE = 4096;
  localparam logic [31:0] SWRST_KEY = 32'h0000_00a5;
endpackage

// ---- src/tick_divider.sv ----
// Purpose: time-base tick generator for the watchdog counter
// Assumes: one clock, synchronous active-low reset
// Notes: one-cycle tick every BASE * 2^select enabled cycles
`timescale 1ns/10ps
module tick_divider
  import window_watchdog_pkg::*;
#(
  parameter int BASE = BASE_DIVIDE
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic [1:0] select,
  // tick out
  output logic tick
);
  // 4096 * 8 fits in 16 bits; width fixed for base below 2^17
  logic [19:0] count_r;
  logic [19:0] limit;

  always_comb
  begin
    limit = 20'(BASE) << select;
  end

  // [RULE10] prescaled tick
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      count_r <= 20'h00000;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      tick <= 1'b0;
    end
    else if (count_r >= limit - 20'h00001)
    begin
      count_r <= 20'h00000;
      tick <= 1'b1;
    end
    else
    begin
      count_r <= count_r + 20'h00001;
      tick <= 1'b0;
    end
  end
endmodule // tick_divider

// ---- src/window_watchdog.sv ----
// Purpose: window watchdog with 7-bit down counter behind APB
// Assumes: pclk is sys_clk; half-word and word writes only
// Notes: reset request and interrupt are registered outputs
//
// Notes on behaviour
// [RULE1] when running, reset request as count falls from 0x40 to 0x3f
// [RULE2] when running, counter write above window requests reset
// [RULE3] warning flag set at 0x40 or early refresh, regardless of enable
// [RULE4] interrupt output only with enable bit 9 set and a warning
// [RULE5] writing zero clears warning flag, one leaves it
// [RULE6] interrupt enable set only by software, cleared by resets
// [RULE7] run bit 7 set by writing one, only hardware reset clears
// [RULE8] after power-on reset watchdog is off, no reset requests
// [RULE9] while running the counter decrements on every tick, wrapping
// [RULE10] tick is clock over 4096 then over 1, 2, 4 or 8
// [RULE11] software refreshes only below window and above 0x3f
// [RULE12] software loads counter above 0x3f with bit 6 set
// [RULE13] timeout is period*4096*2^divider*(low six bits+1)
// [RULE14] counter field reads current value, write loads it
// [RULE15] debug freeze with core halted stops counting
// [RULE16] control resets to 0x7f, window resets to 0x7f
// [RULE17] registers accept half-word and word accesses; the code takes only word writes at the software reset offset
// [RULE18] reset request is a registered one-cycle pulse
`timescale 1ns/10ps
module window_watchdog
  import window_watchdog_pkg::*;
#(
  parameter int BASE = BASE_DIVIDE
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // debug
  input wire logic debugFreeze,
  input wire logic coreHalted,
  // system
  output logic resetRequest,
  output logic earlyWarningInterrupt
);
  ////////////////////////////////////////////////////////////////////
  // state
  logic [6:0] downCount_r;
  logic watchdogRun_r;
  logic [6:0] windowLimit_r;
  logic [1:0] tickDividerSelect_r;
  logic earlyWarningIrqEnable_r;
  logic earlyWarningFlag_r;
  logic tick;
  logic counting;
  logic access;
  logic writeAcc;
  logic lowHalf;
  logic ctrlWrite;
  logic cfgWrite;
  logic statWrite;
  logic swReset;
  logic hitWarn;
  logic hitExpire;
  logic earlyRefresh;
  logic warnEvent;
  logic mapped;

  ////////////////////////////////////////////////////////////////////
  // bus decode
  // single-cycle access phase: pready is high in the cycle after setup
  assign access = psel & penable;
  assign writeAcc = access & pwrite;
  // [RULE17] half-word or word
  assign lowHalf = pstrb[0] & pstrb[1];
  assign mapped = (paddr == CTRL_OFFSET) || (paddr == CFG_OFFSET) ||
                  (paddr == STAT_OFFSET) || (paddr == SWRST_OFFSET);
  assign ctrlWrite = writeAcc & lowHalf & (paddr == CTRL_OFFSET);
  assign cfgWrite = writeAcc & lowHalf & (paddr == CFG_OFFSET);
  assign statWrite = writeAcc & lowHalf & (paddr == STAT_OFFSET);
  assign swReset = writeAcc & (paddr == SWRST_OFFSET) &
                   (pwdata == SWRST_KEY) & (&pstrb);

  ////////////////////////////////////////////////////////////////////
  // time base
  // [RULE15] debug freeze
  assign counting = watchdogRun_r & ~(debugFreeze & coreHalted);

  // [RULE13] timeout from tick period
  // one tick per count step, so the low six bits plus one set the interval
  tick_divider #(
    .BASE(BASE)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(counting),
    .select(tickDividerSelect_r),
    .tick(tick)
  );

  // [RULE1] decrement crossing
  assign hitExpire = tick & counting & ~ctrlWrite &
                     (downCount_r == WARN_VALUE);
  assign hitWarn = tick & counting & ~ctrlWrite &
                   (downCount_r == WARN_VALUE + 7'h01);
  // [RULE2] refresh above window
  assign earlyRefresh = ctrlWrite & watchdogRun_r &
                        (downCount_r > windowLimit_r);
  assign warnEvent = hitWarn | earlyRefresh;

  ////////////////////////////////////////////////////////////////////
  // counter and run bit
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      // [RULE16] control reset value
      downCount_r <= COUNT_RESET;
    end
    // [RULE14] software load
    else if (ctrlWrite)
    begin
      downCount_r <= pwdata[COUNT_MSB:0];
    end
    // [RULE9] free-running decrement
    else if (tick & counting)
    begin
      downCount_r <= downCount_r - 7'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    // [RULE8] disabled after reset
    if (!rst_n)
    begin
      watchdogRun_r <= 1'b0;
    end
    // [RULE7] write one sets
    else if (ctrlWrite & pwdata[RUN_BIT])
    begin
      watchdogRun_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || swReset)
    begin
      windowLimit_r <= WINDOW_RESET;
      tickDividerSelect_r <= DIV_RESET;
    end
    else if (cfgWrite)
    begin
      windowLimit_r <= pwdata[COUNT_MSB:0];
      tickDividerSelect_r <= pwdata[DIV_MSB:DIV_LSB];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    // [RULE6] cleared by resets only
    if (!rst_n || swReset)
    begin
      earlyWarningIrqEnable_r <= 1'b0;
    end
    else if (cfgWrite & pwdata[EARLY_WARNING_IRQ_ENABLE_BIT])
    begin
      earlyWarningIrqEnable_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // early warning
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || swReset)
    begin
      earlyWarningFlag_r <= 1'b0;
    end
    // [RULE3] set wins over clear
    else if (warnEvent)
    begin
      earlyWarningFlag_r <= 1'b1;
    end
    // [RULE5] write zero clears
    else if (statWrite & ~pwdata[EARLY_WARNING_FLAG_BIT])
    begin
      earlyWarningFlag_r <= 1'b0;
    end
  end

  // [RULE4] gated interrupt level
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      earlyWarningInterrupt <= 1'b0;
    end
    else
    begin
      earlyWarningInterrupt <= earlyWarningIrqEnable_r &
                               (earlyWarningFlag_r | warnEvent) &
                               ~(statWrite & ~pwdata[EARLY_WARNING_FLAG_BIT] &
                                 ~warnEvent);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reset request
  // [RULE18] one-cycle registered pulse
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      resetRequest <= 1'b0;
    end
    else
    begin
      resetRequest <= hitExpire | earlyRefresh;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end
    else
    begin
      // ready registered in the setup cycle so the access phase lasts one cycle
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite)
      begin
        unique case (paddr)
          CTRL_OFFSET:
            prdata <= {24'h000000, watchdogRun_r, downCount_r};
          CFG_OFFSET:
            prdata <= {22'h000000, earlyWarningIrqEnable_r,
                       tickDividerSelect_r, windowLimit_r};
          STAT_OFFSET:
            prdata <= {31'h00000000, earlyWarningFlag_r};
          default:
            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // window_watchdog

// ---- verif/window_watchdog_checker.sv ----
// Purpose: port checker for window_watchdog
// Assumes: bound to the top module
// Notes: run and enable bits tracked from bus writes
`timescale 1ns/10ps
module window_watchdog_checker
  import window_watchdog_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // system
  input wire logic resetRequest,
  input wire logic earlyWarningInterrupt
);
  logic runSeen_r;
  logic ewieSeen_r;
  logic wrAcc;
  logic rdAcc;
  assign wrAcc = psel && penable && pwrite && pready;
  assign rdAcc = pready && !pwrite;
  // set-only bits: these only ever grow until a reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      runSeen_r <= 1'b0;
    else if (wrAcc && paddr == CTRL_OFFSET && pwdata[RUN_BIT])
      runSeen_r <= 1'b1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      ewieSeen_r <= 1'b0;
    else if (wrAcc && paddr == SWRST_OFFSET && pwdata == SWRST_KEY)
      ewieSeen_r <= 1'b0;
    else if (wrAcc && paddr == CFG_OFFSET && pwdata[EARLY_WARNING_IRQ_ENABLE_BIT])
      ewieSeen_r <= 1'b1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_ready; s_setup |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("ready too long");
  property p_pulse; resetRequest |=> !resetRequest; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_run; resetRequest |-> runSeen_r; endproperty
  a_run: assert property (p_run) else $error("reset while off");
  property p_irq;
    earlyWarningInterrupt |-> ewieSeen_r || $past(ewieSeen_r);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not enabled");
  property p_map; pready && paddr < 12'h010 |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("error on map");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_early_warning_irq_enable;
    rdAcc && paddr == CFG_OFFSET && ewieSeen_r |-> prdata[EARLY_WARNING_IRQ_ENABLE_BIT];
  endproperty
  a_early_warning_irq_enable: assert property (p_early_warning_irq_enable) else $error("enable lost");
  property p_runrd;
    rdAcc && paddr == CTRL_OFFSET && runSeen_r |-> prdata[RUN_BIT];
  endproperty
  a_runrd: assert property (p_runrd) else $error("run lost");
endmodule // window_watchdog_checker
bind window_watchdog window_watchdog_checker i_chk (.sys_clk(sys_clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .resetRequest(resetRequest),
  .earlyWarningInterrupt(earlyWarningInterrupt));

// ---- verif/tb_window_watchdog.sv ----
// Purpose: self-checking bench for window_watchdog
// Assumes: BASE shortened to 4
// Notes: APB master tasks, one task per scenario
`timescale 1ns/10ps
module tb_window_watchdog;
  import window_watchdog_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic debugFreeze = 1'b0;
  logic coreHalted = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, resetRequest, earlyWarningInterrupt;
  logic [31:0] q;
  logic e;
  int n;
  int miscompares = 0;
  int n_compared = 0;
  window_watchdog #(.BASE(4)) i_window_watchdog (.sys_clk(sys_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .debugFreeze(debugFreeze),
    .coreHalted(coreHalted), .resetRequest(resetRequest),
    .earlyWarningInterrupt(earlyWarningInterrupt));
  always #10 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // entered just after an edge; leaves one idle cycle behind
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      miscompares++;
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic wait_rr(input int lim);
    n = 0;
    while (resetRequest !== 1'b1 && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= lim)
    begin
      miscompares++;
      end_sim();
    end
  endtask
  //////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(CTRL_OFFSET, 32'h0000_007f);
    rd(CFG_OFFSET, 32'h0000_007f);
    rd(STAT_OFFSET, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_expire();
    debugFreeze <= 1'b1;
    coreHalted <= 1'b1;
    apb(1'b1, CTRL_OFFSET, 32'h0000_00c1);
    repeat (20) @(posedge sys_clk);
    rd(CTRL_OFFSET, 32'h0000_00c1);
    apb(1'b1, CTRL_OFFSET, 32'h0000_0041);
    rd(CTRL_OFFSET, 32'h0000_00c1);
    debugFreeze <= 1'b0;
    wait_rr(40);
    // two ticks of four clocks, 0x41 down to 0x3f
    chk(n >= 4 && n <= 11, 1);
    rd(STAT_OFFSET, 32'h1);
    apb(1'b1, STAT_OFFSET, 32'h1);
    rd(STAT_OFFSET, 32'h1);
    apb(1'b1, STAT_OFFSET, 32'h0);
    rd(STAT_OFFSET, 32'h0);
    $display("expiry done");
  endtask
  task automatic t_early();
    apb(1'b1, CFG_OFFSET, 32'h0000_0250);
    rd(CFG_OFFSET, 32'h0000_0250);
    apb(1'b1, CFG_OFFSET, 32'h0000_0050);
    rd(CFG_OFFSET, 32'h0000_0250);
    apb(1'b1, CTRL_OFFSET, 32'h0000_00ff);
    repeat (3) @(posedge sys_clk);
    apb(1'b1, CTRL_OFFSET, 32'h0000_00ff);
    wait_rr(4);
    rd(STAT_OFFSET, 32'h1);
    chk(earlyWarningInterrupt, 1);
    apb(1'b1, SWRST_OFFSET, SWRST_KEY);
    // software reset brings the window back to its reset value
    rd(CFG_OFFSET, 32'h0000_007f);
    chk(q & 32'h0000_0200, 0);
    chk(earlyWarningInterrupt, 0);
    $display("early refresh done");
  endtask
  // count was reloaded to 0x7f; twenty ticks take it under a 0x70 window
  task automatic t_window();
    apb(1'b1, CFG_OFFSET, 32'h0000_0070);
    repeat (80) @(posedge sys_clk);
    apb(1'b1, CTRL_OFFSET, 32'h0000_00ff);
    chk(resetRequest, 0);
    rd(STAT_OFFSET, 32'h0);
    $display("window refresh done");
  endtask
  task automatic t_unmapped();
    rd(12'h010, 32'h0);
    chk(e, 1);
    $display("unmapped done");
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_expire();
    t_early();
    t_window();
    t_unmapped();
    end_sim();
  end
endmodule // tb_window_watchdog
